// file: dv/tb_top.sv
// Self-checking bench for the irq status and role block
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
    n_errors++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); \
    end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import urc_pkg::*;
    localparam int unsigned EP_N = 7;
    // Flag groups by role validity
    localparam logic [12:0] ALW_M = 13'((1 << FLG_FRAME_START) |
        (1 << FLG_WAKEUP_SEEN) | (1 << FLG_SPARE));
    localparam logic [12:0] HOST_M = 13'((1 << FLG_SUPPLY_RAIL_ERROR) |
        (1 << FLG_PEER_DETACH) | (1 << FLG_PEER_ATTACH) |
        (1 << FLG_LATE_SIGNALLING) | (1 << FLG_SUPPLY_FAULT));
    localparam logic [12:0] DEV_M = 13'((1 << FLG_SESSION_END) |
        (1 << FLG_BUS_RESET_SEEN) | (1 << FLG_BUS_IDLE_SEEN));
    localparam logic [12:0] OTG_M = 13'((1 << FLG_SESSION_START) |
        (1 << FLG_CABLE_ROLE_DONE));
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    urc_bus_s bus = '0;
    logic [CTRL_W-1:0] ctrl_evt = '0;
    logic [EP_N:0] ep_in = '0;
    logic [EP_N:0] ep_out = '0;
    logic plug = 1'b0;
    logic a_plug = 1'b0;
    logic swap = 1'b0;
    wire logic [DATA_W-1:0] rdata;
    wire logic attached;
    wire logic id;
    wire logic swp;
    wire logic irq;
    wire logic phy_on;
    wire logic bus_en;
    wire logic sreq;
    logic [31:0] d;
    int n_errors = 0;
    int num_checks = 0;

    // Free-running core clock
    always #5 core_clk_i = ~core_clk_i;

    urc_irq_role #(.EP_PAIRS(EP_N), .OTG_CAPABLE(1'b1)) u_dut (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .bus_i(bus),
        .rdata_o(rdata), .ctrl_evt_i(ctrl_evt), .ep_in_evt_i(ep_in),
        .ep_out_evt_i(ep_out), .cable_id_i(id),
        .cable_attached_i(attached), .role_swap_i(swp), .irq_o(irq),
        .phy_power_on_o(phy_on), .bus_enable_o(bus_en),
        .sess_req_o(sreq));

    urc_peer_model u_peer (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .plug_i(plug),
        .a_plug_i(a_plug), .swap_i(swap), .cable_attached_o(attached),
        .cable_id_o(id), .role_swap_o(swp));

    // Register port cycles
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk_i);
        bus.addr <= a;
        bus.wdata <= v;
        bus.wr <= 1'b1;
        @(posedge core_clk_i);
        bus.wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge core_clk_i);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge core_clk_i);
        bus.rd <= 1'b0;
        #1 v = rdata;
    endtask : rd

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        rd(a, d);
        `CHK(d, e)
    endtask : rchk

    // One-cycle event pulses from the core
    task automatic pulse(input logic [12:0] c, input logic [7:0] i,
                         input logic [7:0] o);
        @(posedge core_clk_i);
        ctrl_evt <= c;
        ep_in <= i;
        ep_out <= o;
        @(posedge core_clk_i);
        ctrl_evt <= '0;
        ep_in <= '0;
        ep_out <= '0;
        #1;
    endtask : pulse

    task automatic wait_role(input logic [31:0] e);
        int k;
        for (k = 0; k < 20; k++) begin
            rd(OFS_ROLE, d);
            if (d === e) break;
        end
        `CHK(d, e)
    endtask : wait_role

    task automatic t_reset();
        `CHK(phy_on, 1'b1)
        `CHK(bus_en, 1'b1)
        `CHK(sreq, 1'b0)
        rchk(OFS_ROLE, 32'h0);
        wr(OFS_EP_COUNT, 32'hff);
        rchk(OFS_EP_COUNT, EP_N);
        rchk(8'hfc, 32'h0);
    endtask : t_reset

    task automatic t_irq();
        wr(OFS_MODE, 32'h08);
        wr(OFS_CTRL_EN, 32'(CTRL_IRQ_FULL_MASK));
        rchk(OFS_CTRL_EN, 32'h1fff);
        wr(OFS_CTRL_DIS, 32'h1fdf);
        rchk(OFS_CTRL_EN, 32'h20);
        pulse(13'h1, 8'h01, 8'h0);
        `CHK(irq, 1'b0)
        pulse(13'h20, 8'h0, 8'h0);
        `CHK(irq, 1'b1)
        rchk(OFS_IRQ_CTRL, 32'h21);
        @(posedge core_clk_i);
        #1 `CHK(irq, 1'b0)
        wr(OFS_EP_EN, 32'h4);
        pulse(13'h0, 8'h04, 8'h0);
        `CHK(irq, 1'b1)
        rchk(OFS_IRQ_EP, 32'h5);
        wr(OFS_EP_DIS, 32'h4);
        rchk(OFS_EP_EN, 32'h0);
        wr(OFS_CTRL_EN, 32'h1fff);
        wr(OFS_EP_EN, 32'hffffffff);
    endtask : t_irq

    task automatic t_dual_host();
        rchk(OFS_ROLE, 32'h10);
        pulse('1, 8'h21, 8'h02);
        rchk(OFS_IRQ_ALL, {3'h0, HOST_M | ALW_M, 16'h0021});
        rchk(OFS_IRQ_CTRL, 32'h0);
        rchk(OFS_IRQ_EP, 32'h0000_0221);
        rchk(OFS_IRQ_EP, 32'h0);
    endtask : t_dual_host

    task automatic t_same();
        pulse(13'h20, 8'h0, 8'h0);
        @(posedge core_clk_i);
        bus.addr <= OFS_IRQ_CTRL;
        bus.rd <= 1'b1;
        ctrl_evt <= 13'h100;
        @(posedge core_clk_i);
        bus.rd <= 1'b0;
        ctrl_evt <= '0;
        #1 `CHK(rdata, 32'h20)
        rchk(OFS_IRQ_CTRL, 32'h100);
    endtask : t_same

    task automatic t_dual_dev();
        wr(OFS_MODE, 32'h10);
        rchk(OFS_ROLE, 32'h20);
        pulse('1, 8'h21, 8'h02);
        rchk(OFS_IRQ_CTRL, 32'(DEV_M | ALW_M));
        rchk(OFS_IRQ_CTRL, 32'h0);
        rchk(OFS_IRQ_EP, 32'h0221_0000);
        wr(OFS_MODE, 32'h0);
        pulse('0, 8'hff, 8'hff);
        rchk(OFS_IRQ_EP, 32'h0);
    endtask : t_dual_dev

    task automatic t_phy();
        wr(OFS_MODE, 32'h0c);
        `CHK(phy_on, 1'b0)
        `CHK(bus_en, 1'b0)
        pulse('1, 8'hff, 8'hff);
        rchk(OFS_IRQ_CTRL, 32'h0);
        rchk(OFS_IRQ_EP, 32'h0);
        wr(OFS_MODE, 32'h08);
        `CHK(phy_on, 1'b1)
    endtask : t_phy

    task automatic t_otg();
        wr(OFS_MODE, 32'h03);
        `CHK(sreq, 1'b1)
        rchk(OFS_MODE, 32'h03);
        wait_role(32'h104);
        pulse('1, 8'h0, 8'h0);
        rchk(OFS_IRQ_CTRL, 32'(DEV_M | ALW_M | OTG_M));
        plug <= 1'b1;
        a_plug <= 1'b1;
        wait_role(32'h101);
        swap <= 1'b1;
        wait_role(32'h102);
        swap <= 1'b0;
        wr(OFS_MODE, 32'h01);
        `CHK(sreq, 1'b0)
        wait_role(32'h100);
        a_plug <= 1'b0;
        // Let the new id level pass the peer and both sync stages
        repeat (4) @(posedge core_clk_i);
        wr(OFS_MODE, 32'h03);
        wait_role(32'h104);
        swap <= 1'b1;
        wait_role(32'h103);
        swap <= 1'b0;
    endtask : t_otg

    task automatic give_verdict();
        if (n_errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict

    // Main sequence after a 16-cycle reset
    initial begin
        repeat (16) @(posedge core_clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_irq();
        t_dual_host();
        t_same();
        t_dual_dev();
        t_phy();
        t_otg();
        give_verdict();
    end

    // Watchdog against a hang
    initial begin
        #50us;
        n_errors++;
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire

// file: dv/urc_peer_model.sv
// Cable peer model driving plug, id and role swap pins
`default_nettype none
module urc_peer_model (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Commands from the bench
    input wire logic plug_i,
    input wire logic a_plug_i,
    input wire logic swap_i,
    // Cable pins
    output logic cable_attached_o,
    output logic cable_id_o,
    output logic role_swap_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pins move only on the clock; id floats high with no plug
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cable_attached_o <= 1'b0;
            cable_id_o <= 1'b1;
            role_swap_o <= 1'b0;
        end else begin
            cable_attached_o <= plug_i;
            cable_id_o <= plug_i ? ~a_plug_i : 1'b1;
            role_swap_o <= plug_i & swap_i;
        end
    end
endmodule : urc_peer_model
`default_nettype wire

// file: hw/urc_irq_role.sv
// Interrupt status, role report and transceiver power logic
//
// Chosen here: the address map and strobed register access.
`default_nettype none
module urc_irq_role
    import urc_pkg::*;
#(
    parameter int unsigned EP_PAIRS = 7,
    parameter bit OTG_CAPABLE = 1'b1
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Register port
    input wire urc_pkg::urc_bus_s bus_i,
    output logic [urc_pkg::DATA_W-1:0] rdata_o,
    // Events from the controller core
    input wire logic [urc_pkg::CTRL_W-1:0] ctrl_evt_i,
    input wire logic [EP_PAIRS:0] ep_in_evt_i,
    input wire logic [EP_PAIRS:0] ep_out_evt_i,
    // Cable side pins
    input wire logic cable_id_i,
    input wire logic cable_attached_i,
    input wire logic role_swap_i,
    // Outputs
    output logic irq_o,
    output logic phy_power_on_o,
    output logic bus_enable_o,
    output logic sess_req_o
);
    import urc_pkg::*;

    localparam int unsigned EP_N = EP_PAIRS + 1;

    // Parameter range check
    generate
        if (EP_PAIRS < 1 || EP_PAIRS > EP_MAX) begin : g_bad_ep
            $error("EP_PAIRS must lie between 1 and 7");
        end
    endgenerate

    // Role state to readout code
    function automatic logic [3:0] role_code(input urc_role_e st);
        case (st)
            RS_A_HOST: role_code = ROLE_A_HOST;
            RS_A_PERI: role_code = ROLE_A_PERIPHERAL;
            RS_B_HOST: role_code = ROLE_B_HOST;
            RS_B_PERI: role_code = ROLE_B_PERIPHERAL;
            default: role_code = ROLE_UNDETERMINED;
        endcase
    endfunction : role_code

    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic swap_q_r;
    logic cable_id_s;
    logic cable_att_s;
    logic swap_rise;

    // Pin synchronisers and swap edge
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
            swap_q_r <= 1'b0;
        end else begin
            sync1_r <= {role_swap_i, cable_attached_i, cable_id_i};
            sync2_r <= sync1_r;
            swap_q_r <= sync2_r[2];
        end
    end

    assign cable_id_s = sync2_r[0];
    assign cable_att_s = sync2_r[1];
    assign swap_rise = sync2_r[2] & ~swap_q_r;

    urc_mode_s mode_r;
    urc_mode_s mode_nxt;
    urc_role_e role_r;
    urc_role_e role_nxt;
    logic run;
    logic is_host;
    logic is_dev;
    logic phy_on;

    // Session runs only in OTG mode with the transceiver up
    assign phy_on = ~mode_r.phy_off;
    assign run = mode_r.otg_mode & mode_r.sess_req & phy_on;

    // Role machine next state
    always_comb begin
        role_nxt = role_r;
        case (role_r)
            RS_NONE: begin
                if (cable_att_s && !cable_id_s) begin
                    role_nxt = RS_A_HOST;
                end else begin
                    role_nxt = RS_B_PERI;
                end
            end
            RS_A_HOST: begin
                if (swap_rise) begin
                    role_nxt = RS_A_PERI;
                end
            end
            RS_A_PERI: begin
                if (swap_rise) begin
                    role_nxt = RS_A_HOST;
                end
            end
            RS_B_PERI: begin
                if (cable_att_s && !cable_id_s) begin
                    role_nxt = RS_A_HOST;
                end else if (swap_rise) begin
                    role_nxt = RS_B_HOST;
                end
            end
            RS_B_HOST: begin
                if (swap_rise) begin
                    role_nxt = RS_B_PERI;
                end
            end
            default: role_nxt = RS_NONE;
        endcase
        if (!run) begin
            role_nxt = RS_NONE;
        end
    end

    // Role machine register
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            role_r <= RS_NONE;
        end else begin
            role_r <= role_nxt;
        end
    end

    // Active role for source gating
    always_comb begin
        if (mode_r.otg_mode) begin
            is_host = (role_r == RS_A_HOST) || (role_r == RS_B_HOST);
            is_dev = (role_r == RS_A_PERI) || (role_r == RS_B_PERI);
        end else begin
            is_host = (mode_r.dual_sel == DUAL_HOST);
            is_dev = (mode_r.dual_sel == DUAL_DEVICE);
        end
    end

    logic [CTRL_W-1:0] ctrl_st_r;
    logic [CTRL_W-1:0] ctrl_st_nxt;
    logic [CTRL_W-1:0] ctrl_ok;
    logic [CTRL_W-1:0] ctrl_set;
    logic [CTRL_W-1:0] ctrl_clr;
    logic [CTRL_W-1:0] cen_r;
    logic [CTRL_W-1:0] cen_nxt;
    logic [DATA_W-1:0] ep_st_r;
    logic [DATA_W-1:0] ep_st_nxt;
    logic [DATA_W-1:0] ep_set;
    logic [DATA_W-1:0] ep_clr;
    logic [DATA_W-1:0] een_r;
    logic [DATA_W-1:0] een_nxt;
    logic [DATA_W-1:0] all_word;
    logic [DATA_W-1:0] role_word;
    logic [DATA_W-1:0] rdata_nxt;
    logic irq_nxt;
    logic irq_r;
    logic rd_all;
    logic rd_ctrl;
    logic rd_ep;

    assign rd_all = bus_i.rd && (bus_i.addr == OFS_IRQ_ALL);
    assign rd_ctrl = bus_i.rd && (bus_i.addr == OFS_IRQ_CTRL);
    assign rd_ep = bus_i.rd && (bus_i.addr == OFS_IRQ_EP);

    // Per-flag role qualification of control events
    always_comb begin
        ctrl_ok = CTRL_IRQ_FULL_MASK;
        ctrl_ok[FLG_SUPPLY_RAIL_ERROR] = is_host;
        ctrl_ok[FLG_SESSION_START] = mode_r.otg_mode;
        ctrl_ok[FLG_SESSION_END] = is_dev;
        ctrl_ok[FLG_PEER_DETACH] = is_host;
        ctrl_ok[FLG_PEER_ATTACH] = is_host;
        ctrl_ok[FLG_LATE_SIGNALLING] = is_host;
        ctrl_ok[FLG_BUS_RESET_SEEN] = is_dev;
        ctrl_ok[FLG_BUS_IDLE_SEEN] = is_dev;
        ctrl_ok[FLG_CABLE_ROLE_DONE] = mode_r.otg_mode;
        ctrl_ok[FLG_SUPPLY_FAULT] = is_host;
        // Nothing latches while the transceiver is down
        ctrl_set = ctrl_evt_i & ctrl_ok & {CTRL_W{phy_on}};
    end

    // Endpoint events sorted into host and peripheral classes
    always_comb begin
        ep_set = '0;
        for (int i = 0; i < EP_N; i++) begin
            ep_set[EP_HIN_LSB + i] = phy_on & is_host & ep_in_evt_i[i];
            ep_set[EP_HOUT_LSB + i] = phy_on & is_host & ep_out_evt_i[i];
            ep_set[EP_DIN_LSB + i] = phy_on & is_dev & ep_in_evt_i[i];
            ep_set[EP_DOUT_LSB + i] = phy_on & is_dev & ep_out_evt_i[i];
        end
    end

    // Combined view and role readout words
    always_comb begin
        all_word = '0;
        all_word[ALL_HIN_LSB +: ALL_EP_W] =
            ep_st_r[EP_HIN_LSB +: ALL_EP_W];
        all_word[ALL_HOUT_LSB +: ALL_EP_W] =
            ep_st_r[EP_HOUT_LSB +: ALL_EP_W];
        all_word[ALL_DIN_LSB +: ALL_EP_W] =
            ep_st_r[EP_DIN_LSB +: ALL_EP_W];
        all_word[ALL_DOUT_LSB +: ALL_EP_W] =
            ep_st_r[EP_DOUT_LSB +: ALL_EP_W];
        all_word[ALL_CTRL_LSB +: CTRL_W] = ctrl_st_r;
        role_word = '0;
        role_word[ROLE_OTG_LSB +: 4] = role_code(role_r);
        if (!mode_r.otg_mode) begin
            if (is_host) begin
                role_word[ROLE_DUAL_LSB +: 2] = DUAL_HOST;
            end else if (is_dev) begin
                role_word[ROLE_DUAL_LSB +: 2] = DUAL_DEVICE;
            end else begin
                role_word[ROLE_DUAL_LSB +: 2] = DUAL_NONE;
            end
        end
        role_word[ROLE_OTGEN_BIT] = mode_r.otg_mode;
    end

    // Register file next values
    always_comb begin
        ctrl_clr = {CTRL_W{rd_all | rd_ctrl}};
        ep_clr = {DATA_W{rd_ep}};
        ctrl_st_nxt = (ctrl_st_r & ~ctrl_clr) | ctrl_set;
        ep_st_nxt = (ep_st_r & ~ep_clr) | ep_set;
        cen_nxt = cen_r;
        een_nxt = een_r;
        mode_nxt = mode_r;
        if (bus_i.wr) begin
            case (bus_i.addr)
                OFS_CTRL_EN: cen_nxt = cen_r | bus_i.wdata[CTRL_W-1:0];
                OFS_CTRL_DIS: cen_nxt = cen_r & ~bus_i.wdata[CTRL_W-1:0];
                OFS_EP_EN: een_nxt = een_r | bus_i.wdata;
                OFS_EP_DIS: een_nxt = een_r & ~bus_i.wdata;
                OFS_MODE: begin
                    mode_nxt = urc_mode_s'(bus_i.wdata[MODE_W-1:0]);
                    mode_nxt.otg_mode =
                        bus_i.wdata[0] & OTG_CAPABLE;
                end
                default: mode_nxt = mode_r;
            endcase
        end
        rdata_nxt = '0;
        if (bus_i.rd) begin
            case (bus_i.addr)
                OFS_IRQ_ALL: rdata_nxt = all_word;
                OFS_IRQ_CTRL: rdata_nxt = {19'h0, ctrl_st_r};
                OFS_IRQ_EP: rdata_nxt = ep_st_r;
                OFS_CTRL_EN: rdata_nxt = {19'h0, cen_r};
                OFS_CTRL_DIS: rdata_nxt = {19'h0, cen_r};
                OFS_EP_EN: rdata_nxt = een_r;
                OFS_EP_DIS: rdata_nxt = een_r;
                OFS_MODE: rdata_nxt = {27'h0, mode_r};
                OFS_ROLE: rdata_nxt = role_word;
                OFS_EP_COUNT: rdata_nxt = DATA_W'(EP_PAIRS);
                default: rdata_nxt = '0;
            endcase
        end
        irq_nxt = (|(ctrl_st_nxt & cen_nxt)) |
            (|(ep_st_nxt & een_nxt));
    end

    // Register file flops
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_st_r <= '0;
            ep_st_r <= '0;
            cen_r <= '0;
            een_r <= '0;
            mode_r <= urc_mode_s'(MODE_RESET);
            rdata_o <= '0;
            irq_r <= 1'b0;
        end else begin
            ctrl_st_r <= ctrl_st_nxt;
            ep_st_r <= ep_st_nxt;
            cen_r <= cen_nxt;
            een_r <= een_nxt;
            mode_r <= mode_nxt;
            rdata_o <= rdata_nxt;
            irq_r <= irq_nxt;
        end
    end

    // Outputs from registered state
    assign irq_o = irq_r;
    assign phy_power_on_o = phy_on;
    assign bus_enable_o = phy_on;
    assign sess_req_o = run;

    // Checks
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    sequence ctrl_clear_read;
        (rd_all || rd_ctrl) && (ctrl_set == '0);
    endsequence

    sequence quiet_window;
        (ctrl_set == '0) [*2];
    endsequence

    all_read_clr_a: assert property (rd_all && (ctrl_set == '0)
        |=> (ctrl_st_r == '0))
        else $error("combined read left control bits set");
    ctrl_read_clr_a: assert property (ctrl_clear_read
        ##1 quiet_window |-> (ctrl_st_r == '0))
        else $error("control read left control bits set");
    ep_read_clr_a: assert property (rd_ep && (ep_set == '0)
        |=> (ep_st_r == '0))
        else $error("endpoint read left endpoint bits set");
    set_wins_a: assert property ((ctrl_set != '0)
        |=> ((ctrl_st_r & $past(ctrl_set)) == $past(ctrl_set)))
        else $error("control event lost");
    irq_mask_a: assert property (((ctrl_st_r & cen_r) == '0)
        && ((ep_st_r & een_r) == '0) |-> !irq_o)
        else $error("interrupt raised by disabled source");
    host_only_a: assert property (!is_host
        && !ctrl_st_r[FLG_PEER_ATTACH] |=> !ctrl_st_r[FLG_PEER_ATTACH])
        else $error("attach flagged outside host mode");
    dev_only_a: assert property (!is_dev
        && !ctrl_st_r[FLG_BUS_RESET_SEEN]
        |=> !ctrl_st_r[FLG_BUS_RESET_SEEN])
        else $error("bus reset flagged outside device mode");
    no_cable_a: assert property ((role_r == RS_NONE) && run
        && !cable_att_s |=> (role_r == RS_B_PERI))
        else $error("no cable session did not pick B peripheral");
    phy_off_a: assert property (mode_r.phy_off
        && (ctrl_st_r == '0) && (ep_st_r == '0)
        |-> !bus_enable_o ##1 ((ctrl_st_r == '0) && (ep_st_r == '0)))
        else $error("activity while transceiver is off");
    role_read_a: assert property (bus_i.rd
        && (bus_i.addr == OFS_ROLE)
        |=> (rdata_o[3:0] == role_code($past(role_r))))
        else $error("role readout disagrees with role machine");
    stop_sess_a: assert property (!run |=> (role_r == RS_NONE))
        else $error("role kept after session ended");
    rdata_idle_a: assert property (!bus_i.rd |=> (rdata_o == '0))
        else $error("read data outside read answer cycle");
endmodule : urc_irq_role
`default_nettype wire

// file: hw/urc_pkg.sv
// Constants and types for the irq status and role block
`default_nettype none
package urc_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned CTRL_W = 13;
    localparam int unsigned EP_MAX = 7;

    // Register byte offsets
    localparam logic [7:0] OFS_IRQ_ALL = 8'h00;
    localparam logic [7:0] OFS_IRQ_CTRL = 8'h04;
    localparam logic [7:0] OFS_IRQ_EP = 8'h08;
    localparam logic [7:0] OFS_CTRL_EN = 8'h0c;
    localparam logic [7:0] OFS_CTRL_DIS = 8'h10;
    localparam logic [7:0] OFS_EP_EN = 8'h14;
    localparam logic [7:0] OFS_EP_DIS = 8'h18;
    localparam logic [7:0] OFS_MODE = 8'h1c;
    localparam logic [7:0] OFS_ROLE = 8'h20;
    localparam logic [7:0] OFS_EP_COUNT = 8'h24;

    // Control flag positions, shared by status, enable and disable
    localparam int unsigned FLG_SUPPLY_RAIL_ERROR = 0;
    localparam int unsigned FLG_SESSION_START = 1;
    localparam int unsigned FLG_SESSION_END = 2;
    localparam int unsigned FLG_PEER_DETACH = 3;
    localparam int unsigned FLG_PEER_ATTACH = 4;
    localparam int unsigned FLG_FRAME_START = 5;
    localparam int unsigned FLG_LATE_SIGNALLING = 6;
    localparam int unsigned FLG_BUS_RESET_SEEN = 7;
    localparam int unsigned FLG_WAKEUP_SEEN = 8;
    localparam int unsigned FLG_BUS_IDLE_SEEN = 9;
    localparam int unsigned FLG_CABLE_ROLE_DONE = 10;
    localparam int unsigned FLG_SUPPLY_FAULT = 11;
    localparam int unsigned FLG_SPARE = 12;
    localparam logic [CTRL_W-1:0] CTRL_IRQ_FULL_MASK = 13'h1fff;

    // Combined view: endpoints 0..3 of each class, then control flags
    localparam int unsigned ALL_EP_W = 4;
    localparam int unsigned ALL_HIN_LSB = 0;
    localparam int unsigned ALL_HOUT_LSB = 4;
    localparam int unsigned ALL_DIN_LSB = 8;
    localparam int unsigned ALL_DOUT_LSB = 12;
    localparam int unsigned ALL_CTRL_LSB = 16;

    // Endpoint word: host class low half, peripheral class high half
    localparam int unsigned EP_CLASS_W = 8;
    localparam int unsigned EP_HIN_LSB = 0;
    localparam int unsigned EP_HOUT_LSB = 8;
    localparam int unsigned EP_DIN_LSB = 16;
    localparam int unsigned EP_DOUT_LSB = 24;

    // Role readout codes and positions
    localparam logic [3:0] ROLE_UNDETERMINED = 4'h0;
    localparam logic [3:0] ROLE_A_HOST = 4'h1;
    localparam logic [3:0] ROLE_A_PERIPHERAL = 4'h2;
    localparam logic [3:0] ROLE_B_HOST = 4'h3;
    localparam logic [3:0] ROLE_B_PERIPHERAL = 4'h4;
    localparam logic [1:0] DUAL_NONE = 2'h0;
    localparam logic [1:0] DUAL_HOST = 2'h1;
    localparam logic [1:0] DUAL_DEVICE = 2'h2;
    localparam int unsigned ROLE_OTG_LSB = 0;
    localparam int unsigned ROLE_DUAL_LSB = 4;
    localparam int unsigned ROLE_OTGEN_BIT = 8;
    localparam int unsigned MODE_W = 5;
    localparam logic [MODE_W-1:0] MODE_RESET = 5'h00;

    typedef enum logic [4:0] {
        RS_NONE = 5'b00001,
        RS_A_HOST = 5'b00010,
        RS_A_PERI = 5'b00100,
        RS_B_PERI = 5'b01000,
        RS_B_HOST = 5'b10000
    } urc_role_e;

    // Mode control word, low bits of the mode register
    typedef struct packed {
        logic [1:0] dual_sel;
        logic phy_off;
        logic sess_req;
        logic otg_mode;
    } urc_mode_s;

    // Register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } urc_bus_s;
endpackage : urc_pkg
`default_nettype wire
